// ---- ntb_pkg.sv ----
// Shared constants, types and helpers for the tape block formatter and checker
package ntb_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_KHZ = 100000;
  localparam int LP_PRE_MILS = 1700;
  localparam int LP_POST_MILS = 500;
  localparam int IBG7_MILS = 750;
  localparam int IBG9_MILS = 600;
  localparam int IBG_MAX_FEET = 25;
  localparam logic [3:0] CRC_CELLS = 4'h4;

  // ********************************************************************
  // Character values
  // ********************************************************************
  localparam logic [5:0] ZERO_CHAR = 6'h00;
  localparam logic [5:0] ZERO_SUB_CHAR = 6'h0A;
  localparam logic [8:0] ERASE_LEVEL = 9'h000;

  // ********************************************************************
  // Register map and fields
  // ********************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RDDATA = 8'h0C;
  localparam int CMD_LOADPT = 0;
  localparam int CMD_GAP = 1;
  localparam int CMD_START = 2;
  localparam int CMD_END = 3;
  localparam int CMD_FMARK = 4;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LP_PRE = 3'b001,
    ST_LP_POST = 3'b010,
    ST_GAP = 3'b011,
    ST_DATA = 3'b100,
    ST_TAIL = 3'b101
  } ntb_state_type;

  // One character cell across all nine tracks, parity track on top
  typedef struct packed {
    logic par;
    logic [7:0] data;
  } ntb_frame_type;

  typedef struct packed {
    logic zsub;
    logic even;
    logic nine;
  } ntb_ctrl_type;

  typedef struct packed {
    logic rd_in_block;
    logic lp_short;
    logic crc_err;
    logic lrc_err;
    logic par_err;
    logic [2:0] state;
  } ntb_status_type;

  // Least time in mils at a tape speed, rounded up to whole clock cycles
  function automatic int mils_to_cyc(input int mils, input int ips);
    return (mils * CLK_KHZ + ips - 1) / ips;
  endfunction

endpackage

// ---- ntb_sync.sv ----
// Two-stage synchroniser bank for inputs from outside the pclk domain
`timescale 1ns/10ps
module ntb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- ntb_format.sv ----
// NRZI tape block formatter (write) and block checker (read) with APB registers
`timescale 1ns/10ps

// What this block does
// - Gaps hold head current at erased polarity
// - No read data output across erased gaps
// - Load point erase 1.7in before, 0.5in after
// - File mark is one character plus check
// - Six or eight data tracks plus parity
// - Write parity bit makes odd or even count
// - Read parity mismatch raises error line
// - Parity selectable on seven, odd on nine
// - Longitudinal check character ends every block
// - Longitudinal bit makes each track count even
// - Read flags any odd track count
// - Nine-track cyclic check four cells after data
// - Character codes pass through unchanged
// - Optional seven-track zero character recorded as 001010
// - Per-track toggle flip-flop on one bits
// - Read transition is one, none is zero
module ntb_format
  import ntb_pkg::*;
#(
  parameter int TAPE_IPS = 75,
  parameter int LP_PRE_CYC = mils_to_cyc(LP_PRE_MILS, TAPE_IPS),
  parameter int LP_POST_CYC = mils_to_cyc(LP_POST_MILS, TAPE_IPS),
  parameter int IBG7_CYC = mils_to_cyc(IBG7_MILS, TAPE_IPS),
  parameter int IBG9_CYC = mils_to_cyc(IBG9_MILS, TAPE_IPS),
  parameter int CELL_CYC = 1667,
  parameter logic [3:0] LRC_CELLS = 4'h8,
  parameter int RD_END_CYC = 1667 * 10,
  parameter logic [7:0] CRC_POLY = 8'h1D,
  parameter logic [7:0] FM_CHAR7 = 8'h0F,
  parameter logic [7:0] FM_CHAR9 = 8'h13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_clk,
  input wire logic [7:0] wr_data,
  input wire logic load_point_marker,
  output logic [8:0] head_wr,
  output logic head_wr_strobe,
  output logic write_gap,
  input wire logic rd_clk,
  input wire logic [8:0] rd_flux,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_error,
  output logic rd_in_gap,
  output logic [2:0] rd_check_err
);

  // ********************************************************************
  // Helpers
  // ********************************************************************

  // Build a written frame: mask to track count, substitute zero, add parity
  function automatic ntb_frame_type build_frame(input logic [7:0] din, input ntb_ctrl_type c);
    ntb_frame_type f;
    f.data = c.nine ? din : {2'b00, din[5:0]};
    if (!c.nine && c.zsub && f.data[5:0] == ZERO_CHAR) begin
      f.data = {2'b00, ZERO_SUB_CHAR};
    end
    f.par = (!c.nine && c.even) ? ^f.data : ~^f.data;
    return f;
  endfunction

  // One byte step of the cyclic check register
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] x;
    x = crc ^ d;
    return x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
  endfunction

  // ********************************************************************
  // Input synchronisers and edges
  // ********************************************************************
  logic [19:0] pins_s;
  logic wr_clk_s, marker_s, rd_clk_s;
  logic [7:0] wr_data_s;
  logic [8:0] flux_s;
  logic wr_clk_d, marker_d, rd_clk_d;
  logic wr_clk_rise, marker_fall, rd_clk_rise;

  ntb_sync #(.WIDTH(20)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({wr_clk, wr_data, load_point_marker, rd_clk, rd_flux}),
    .sync_out(pins_s)
  );

  assign {wr_clk_s, wr_data_s, marker_s, rd_clk_s, flux_s} = pins_s;

  // Edge history taken from the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_clk_d <= 1'b0;
      marker_d <= 1'b0;
      rd_clk_d <= 1'b0;
    end else begin
      wr_clk_d <= wr_clk_s;
      marker_d <= marker_s;
      rd_clk_d <= rd_clk_s;
    end
  end

  assign wr_clk_rise = wr_clk_s & ~wr_clk_d;
  assign marker_fall = ~marker_s & marker_d;
  assign rd_clk_rise = rd_clk_s & ~rd_clk_d;

  // ********************************************************************
  // APB slave
  // ********************************************************************
  ntb_ctrl_type ctrl;
  ntb_status_type status;
  ntb_state_type state;
  logic mapped, wr_acc;
  logic [4:0] cmd;
  logic par_err, lrc_err, crc_err, lp_short, rd_in_block;

  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) ||
                  (paddr == ADDR_STATUS) || (paddr == ADDR_RDDATA);
  assign wr_acc = psel & penable & pwrite & mapped;
  assign cmd = (wr_acc && paddr == ADDR_CMD) ? pwdata[4:0] : 5'h00;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign status = '{rd_in_block: rd_in_block, lp_short: lp_short, crc_err: crc_err,
                    lrc_err: lrc_err, par_err: par_err, state: state};

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_acc && paddr == ADDR_CTRL) begin
      ctrl <= pwdata[2:0];
    end
  end

  // Read data registered in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL: prdata <= {29'h0, ctrl};
        ADDR_STATUS: prdata <= {24'h0, status};
        ADDR_RDDATA: prdata <= {24'h0, rd_data};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************************
  // Write sequencer
  // ********************************************************************
  logic [31:0] gap_cnt;
  logic [31:0] cell_cnt;
  logic [3:0] cell_idx, next_cell;
  logic cell_tick, fm_block, in_gap;
  logic emit_go, emit_fold, emit_lrc;
  ntb_frame_type emit_frame;
  logic [8:0] lrc_wr;
  logic [7:0] crc_wr;
  logic [31:0] ibg_cyc;

  assign in_gap = (state == ST_LP_PRE) || (state == ST_LP_POST) || (state == ST_GAP);
  assign ibg_cyc = ctrl.nine ? 32'(IBG9_CYC) : 32'(IBG7_CYC);
  assign cell_tick = (state == ST_TAIL) && (cell_cnt == 32'(CELL_CYC - 1));
  assign next_cell = cell_idx + 4'h1;

  // Pick the one character, if any, recorded this cycle
  always_comb begin
    emit_go = 1'b0;
    emit_fold = 1'b0;
    emit_lrc = 1'b0;
    emit_frame = '0;
    if (state == ST_DATA && wr_clk_rise) begin
      emit_go = 1'b1;
      emit_fold = 1'b1;
      emit_frame = build_frame(wr_data_s, ctrl);
    end else if (state == ST_IDLE && cmd[CMD_FMARK]) begin
      emit_go = 1'b1;
      emit_fold = 1'b1;
      emit_frame = build_frame(ctrl.nine ? FM_CHAR9 : FM_CHAR7, ctrl);
    end else if (cell_tick && next_cell == CRC_CELLS && ctrl.nine && !fm_block) begin
      emit_go = 1'b1;
      emit_fold = 1'b1;
      emit_frame = build_frame(crc_wr, ctrl);
    end else if (cell_tick && next_cell == LRC_CELLS) begin
      emit_go = 1'b1;
      emit_lrc = 1'b1;
      emit_frame = lrc_wr;
    end
  end

  // Sequencer state; commands other than end are taken only when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd[CMD_LOADPT]) state <= ST_LP_PRE;
          else if (cmd[CMD_GAP]) state <= ST_GAP;
          else if (cmd[CMD_START]) state <= ST_DATA;
          else if (cmd[CMD_FMARK]) state <= ST_TAIL;
        end
        ST_LP_PRE: if (marker_fall) state <= ST_LP_POST;
        ST_LP_POST: if (gap_cnt >= 32'(LP_POST_CYC - 1)) state <= ST_IDLE;
        ST_GAP: if (gap_cnt >= ibg_cyc - 32'h1) state <= ST_IDLE;
        ST_DATA: if (cmd[CMD_END]) state <= ST_TAIL;
        ST_TAIL: if (emit_lrc) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Gap length counter, restarted on every gap entry and at the marker edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 32'h0000_0000;
    end else if (!in_gap || (state == ST_LP_PRE && marker_fall)) begin
      gap_cnt <= 32'h0000_0000;
    end else if (gap_cnt != 32'hFFFF_FFFF) begin
      gap_cnt <= gap_cnt + 32'h1;
    end
  end

  // Flag a load point erase that began too late before the marker edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_short <= 1'b0;
    end else begin
      lp_short <= (lp_short & ~(state == ST_IDLE && cmd[CMD_LOADPT])) |
                  (state == ST_LP_PRE && marker_fall && gap_cnt < 32'(LP_PRE_CYC));
    end
  end

  // Character cell timer after the last data character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_cnt <= 32'h0000_0000;
      cell_idx <= 4'h0;
    end else if (state != ST_TAIL) begin
      cell_cnt <= 32'h0000_0000;
      cell_idx <= 4'h0;
    end else if (cell_tick) begin
      cell_cnt <= 32'h0000_0000;
      cell_idx <= next_cell;
    end else begin
      cell_cnt <= cell_cnt + 32'h1;
    end
  end

  // Block-wide check accumulators, reset once per block, not per record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lrc_wr <= 9'h000;
      crc_wr <= 8'h00;
      fm_block <= 1'b0;
    end else if (state == ST_IDLE && (cmd[CMD_START] || cmd[CMD_FMARK])) begin
      lrc_wr <= emit_fold ? emit_frame : 9'h000;
      crc_wr <= 8'h00;
      fm_block <= cmd[CMD_FMARK];
    end else if (emit_fold) begin
      lrc_wr <= lrc_wr ^ emit_frame;
      crc_wr <= crc_step(crc_wr, emit_frame.data);
    end
  end

  // Head current: erased level in gaps, per-track toggle on ones otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_wr <= ERASE_LEVEL;
      head_wr_strobe <= 1'b0;
      write_gap <= 1'b0;
    end else begin
      head_wr_strobe <= emit_go;
      write_gap <= in_gap;
      if (in_gap) begin
        head_wr <= ERASE_LEVEL;
      end else if (emit_go) begin
        head_wr <= head_wr ^ emit_frame;
      end
    end
  end

  // ********************************************************************
  // Read checker
  // ********************************************************************
  logic [8:0] last_flux, rd_bits;
  logic rd_char, rd_start, rd_end, pend_par;
  logic [31:0] idle_cnt;
  logic [8:0] lrc_rd;
  logic [7:0] crc_rd, prev1, prev2;
  logic [1:0] rd_cnt;
  logic par_bad;

  assign rd_bits = flux_s ^ last_flux;
  assign rd_char = rd_clk_rise && (rd_bits != 9'h000);
  assign rd_start = rd_char && !rd_in_block;
  assign rd_end = rd_in_block && !rd_char && (idle_cnt >= 32'(RD_END_CYC - 1));
  assign par_bad = (!ctrl.nine && ctrl.even) ? ^rd_bits : ~^rd_bits;
  assign rd_in_gap = ~rd_in_block;
  assign rd_check_err = {crc_err, lrc_err, par_err};

  // Flux history and block presence; a long quiet spell ends the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_flux <= 9'h000;
      rd_in_block <= 1'b0;
      idle_cnt <= 32'h0000_0000;
    end else begin
      if (rd_clk_rise) last_flux <= flux_s;
      if (rd_char) begin
        rd_in_block <= 1'b1;
        idle_cnt <= 32'h0000_0000;
      end else if (rd_end) begin
        rd_in_block <= 1'b0;
      end else if (rd_in_block) begin
        idle_cnt <= idle_cnt + 32'h1;
      end
    end
  end

  // Data out only for real characters, never while crossing a gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_char;
      if (rd_char) rd_data <= ctrl.nine ? rd_bits[7:0] : {2'b00, rd_bits[5:0]};
    end
  end

  // Running checks; the last character is the longitudinal one and skips parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lrc_rd <= 9'h000;
      crc_rd <= 8'h00;
      prev1 <= 8'h00;
      prev2 <= 8'h00;
      rd_cnt <= 2'h0;
      pend_par <= 1'b0;
    end else if (rd_start) begin
      lrc_rd <= rd_bits;
      crc_rd <= 8'h00;
      prev1 <= rd_bits[7:0];
      prev2 <= 8'h00;
      rd_cnt <= 2'h1;
      pend_par <= par_bad;
    end else if (rd_char) begin
      lrc_rd <= lrc_rd ^ rd_bits;
      if (rd_cnt == 2'h2) crc_rd <= crc_step(crc_rd, prev2);
      prev2 <= prev1;
      prev1 <= rd_bits[7:0];
      if (rd_cnt != 2'h2) rd_cnt <= rd_cnt + 2'h1;
      pend_par <= par_bad;
    end
  end

  // Sticky error flags; a new block clears them and none can be set in that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_err <= 1'b0;
      lrc_err <= 1'b0;
      crc_err <= 1'b0;
      rd_error <= 1'b0;
    end else begin
      rd_error <= rd_char && !rd_start && pend_par;
      par_err <= (par_err & ~rd_start) | (rd_char && !rd_start && pend_par);
      lrc_err <= (lrc_err & ~rd_start) | (rd_end && lrc_rd != 9'h000);
      crc_err <= (crc_err & ~rd_start) |
                 (rd_end && ctrl.nine && rd_cnt == 2'h2 && crc_rd != prev2);
    end
  end

endmodule

// ---- ntb_format_chk.sv ----
// Concurrent checks on the tape block formatter ports
`timescale 1ns/10ps
module ntb_format_chk
  import ntb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic [8:0] head_wr,
  input wire logic head_wr_strobe,
  input wire logic write_gap,
  input wire logic rd_clk,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic rd_in_gap,
  input wire logic [2:0] rd_check_err
);
  // ******************************
  // Properties
  // ******************************
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Erase lands with the first write_gap cycle; the property checks from the second gap cycle
  sequence s_gap_held;
    write_gap ##1 write_gap;
  endsequence
  sequence s_one_pulse;
    head_wr_strobe ##1 !head_wr_strobe;
  endsequence
  a_gap_erased: assert property (s_gap_held |-> head_wr == ERASE_LEVEL)
    else $error("head current not erased in gap");
  a_gap_no_cell: assert property (write_gap |-> !head_wr_strobe)
    else $error("cell written during gap");
  a_strobe_single: assert property (head_wr_strobe |-> s_one_pulse)
    else $error("write strobe too long");
  a_head_cause: assert property ($changed(head_wr) |-> head_wr_strobe || write_gap)
    else $error("head current moved without a cell");
  a_read_strobed: assert property (rd_valid |->
    $past(rd_clk, 2) || $past(rd_clk, 3) || $past(rd_clk, 4))
    else $error("read character without strobe");
  a_read_leaves_gap: assert property (rd_valid |=> !rd_in_gap)
    else $error("character reported inside gap");
  a_error_with_char: assert property (rd_error |-> rd_valid)
    else $error("parity error without character");
  a_error_sticks: assert property (rd_error |=> rd_check_err[0])
    else $error("parity flag not set");
  a_flags_clear: assert property (($past(rd_check_err) & ~rd_check_err) != 3'h0 |->
    $past(rd_valid) or ##[0:2] rd_valid)
    else $error("flag cleared outside block start");
  a_unmapped_err: assert property (psel && penable && paddr > ADDR_RDDATA |-> pslverr)
    else $error("unmapped access not refused");
endmodule

bind ntb_format ntb_format_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .head_wr, .head_wr_strobe, .write_gap, .rd_clk, .rd_valid, .rd_error, .rd_in_gap,
  .rd_check_err);

// ---- ntb_tape_model.sv ----
// Controller write link and tape head read link, behavioural
`timescale 1ns/10ps
module ntb_tape_model (
  input wire logic pclk,
  output logic wr_clk,
  output logic [7:0] wr_data,
  output logic rd_clk,
  output logic [8:0] rd_flux
);
  // ******************************
  // Link strobes, still between characters
  // ******************************
  initial begin
    wr_clk = 1'b0;
    wr_data = 8'h00;
    rd_clk = 1'b0;
    rd_flux = 9'h000;
  end
  // Half of the 80 ns link period
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask
  // Data moves only while the strobe is low, so a late sample still catches the same character
  task automatic put_wr(input logic [7:0] c);
    wr_data <= c;
    half();
    wr_clk <= 1'b1;
    half();
    wr_clk <= 1'b0;
  endtask
  // Tracks with a one change flux, others keep it
  task automatic put_rd(input logic [8:0] f);
    rd_flux <= rd_flux ^ f;
    half();
    rd_clk <= 1'b1;
    half();
    rd_clk <= 1'b0;
  endtask
endmodule

// ---- ntb_format_tb.sv ----
// Self-checking bench for the tape block formatter
`timescale 1ns/10ps
module ntb_format_tb
  import ntb_pkg::*;
();
  localparam int CELL = 20;
  localparam int IBG9 = 50;
  localparam int LPP = 50;
  localparam logic [7:0] FMARK9 = 8'h13;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic load_point_marker = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, wr_clk, head_wr_strobe, write_gap, rd_clk, rd_valid, rd_error;
  logic rd_in_gap, err;
  logic [7:0] wr_data, rd_data;
  logic [8:0] head_wr, rd_flux, hw_prev, d;
  logic [2:0] rd_check_err;
  logic [10:0] wq[$];
  logic [8:0] rq[$];
  logic [10:0] e;
  logic [8:0] acc = 9'h000;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t_crc = 0;
  int t_dat = 0;
  int n;
  // ******************************
  // Harness
  // ******************************
  ntb_format #(.LP_PRE_CYC(50), .LP_POST_CYC(LPP), .IBG7_CYC(60), .IBG9_CYC(IBG9),
    .FM_CHAR9(FMARK9),
    .CELL_CYC(CELL), .RD_END_CYC(250)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .wr_clk, .wr_data, .load_point_marker,
    .head_wr, .head_wr_strobe, .write_gap, .rd_clk, .rd_flux, .rd_data, .rd_valid,
    .rd_error, .rd_in_gap, .rd_check_err);
  ntb_tape_model u_tape (.pclk, .wr_clk, .wr_data, .rd_clk, .rd_flux);
  // 100 MHz system clock
  always #5 pclk = ~pclk;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One APB transfer, held until pready is seen at an access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // A written block; its cells are noted for the head monitor
  task automatic wr_block(input logic [2:0] ctrl);
    logic [7:0] c;
    logic [7:0] v;
    apb(1'b1, ADDR_CTRL, {29'h0, ctrl});
    apb(1'b1, ADDR_CMD, 32'h1 << CMD_START);
    for (int i = 0; i < 5; i++) begin
      c = 8'($urandom);
      if (i == 1 && ctrl[2]) c[5:0] = 6'h00;
      v = ctrl[0] ? c : {2'b00, c[5:0]};
      if (!ctrl[0] && ctrl[2] && v == 8'h00) v = {2'b00, ZERO_SUB_CHAR};
      wq.push_back({2'd0, (ctrl[0] || !ctrl[1]) ? ~^v : ^v, v});
      u_tape.put_wr(c);
    end
    apb(1'b1, ADDR_CMD, 32'h1 << CMD_END);
    if (ctrl[0]) wq.push_back(11'h200);
    wq.push_back(ctrl[0] ? 11'h600 : 11'h400);
    repeat (10 * CELL) @(posedge pclk);
    check(wq.size(), 0);
  endtask
  // Three characters and a check character, with optional faults
  task automatic rd_block(input int bad, input logic bad_lrc);
    logic [8:0] f;
    logic [8:0] l;
    l = 9'h000;
    for (int i = 0; i < 4; i++) begin
      // Track 1 always set, so no character or check character is blank
      f[7:0] = 8'($urandom & 32'h3F) | 8'h02;
      f[8] = ~^f[7:0] ^ (i == bad);
      if (i == 3) f = l ^ {8'h00, bad_lrc};
      l = l ^ f;
      rq.push_back({i > 0 && i - 1 == bad, f[7:0]});
      u_tape.put_rd(f);
    end
    repeat (300) @(posedge pclk);
    check(rd_check_err, {1'b0, bad_lrc, bad >= 0});
    check(rd_in_gap, 1'b1);
  endtask
  // Head monitor: tracks that toggled form the cell; longitudinal check cells close the column sums
  always @(posedge pclk) begin
    hw_prev <= head_wr;
    if (head_wr_strobe === 1'b1) begin
      d = head_wr ^ hw_prev;
      e = (wq.size() > 0) ? wq.pop_front() : 11'h7FF;
      if (e[10:9] == 2'd0) check(d, e[8:0]);
      if (e[10:9] == 2'd0) t_dat = cyc;
      if (e[10:9] == 2'd1) check(^d, 1'b1);
      if (e[10:9] == 2'd1) check((cyc - t_dat) / CELL, 4);
      if (e[10:9] == 2'd1) t_crc = cyc;
      if (e[10:9] == 2'd3) check(cyc - t_crc, 4 * CELL);
      if (e[10]) check(d, acc);
      acc = e[10] ? 9'h000 : acc ^ d;
    end
  end
  // Read monitor, in arrival order
  always @(posedge pclk) begin
    if (rd_valid === 1'b1) begin
      check({rd_error, rd_data}, (rq.size() > 0) ? rq.pop_front() : 9'h1FF);
      check(rd_in_gap, 1'b0);
    end
  end
  // Cycle count and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    void'($urandom(32'hB90A));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check({err, q}, {a == 16, 32'h0});
    end
    $display("test registers done");
    wr_block(3'h3);
    wr_block(3'h0);
    wr_block(3'h6);
    apb(1'b1, ADDR_CTRL, 32'h1);
    wq.push_back({2'd0, ~^FMARK9, FMARK9});
    wq.push_back(11'h400);
    apb(1'b1, ADDR_CMD, 32'h1 << CMD_FMARK);
    repeat (10 * CELL) @(posedge pclk);
    check(wq.size(), 0);
    $display("test write blocks done");
    apb(1'b1, ADDR_CMD, 32'h1 << CMD_GAP);
    for (n = 0; write_gap !== 1'b1 && n < 9; n++) @(posedge pclk);
    for (n = 0; write_gap !== 1'b0 && n < 999; n++) @(posedge pclk);
    check(n > IBG9 - 5 && n < IBG9 + 5, 1'b1);
    // Marker held long enough first, then too briefly
    for (int s = 0; s < 2; s++) begin
      load_point_marker <= 1'b1;
      apb(1'b1, ADDR_CMD, 32'h1 << CMD_LOADPT);
      repeat (s ? 10 : 60) @(posedge pclk);
      load_point_marker <= 1'b0;
      for (n = 0; write_gap !== 1'b0 && n < 999; n++) @(posedge pclk);
      check(n > LPP - 1 && n < LPP + 6, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(q[6], s[0]);
    end
    $display("test gaps done");
    apb(1'b1, ADDR_CTRL, 32'h0);
    rd_block(-1, 1'b0);
    rd_block(1, 1'b1);
    rd_block(-1, 1'b0);
    $display("test read blocks done");
    final_report();
  end
endmodule
